// File: pixel_feed.sv
// Purpose: Sensor readout source and output-circuit sink around the pixel stage
// Assumes: One pixel per clock at most, no backpressure
// Notes:   Idle data lines show the inverse of the last pixel, never a stale copy
`timescale 1ns/1ps
module pixel_feed (
   // Clock
   input  wire logic             CLOCK,
   // Stream
   input  pixel_lut_pkg::pixel_s PIX_OUT,
   output pixel_lut_pkg::pixel_s PIX_IN
);
   int         cyc;
   int         t_in[$];
   int         lat[$];
   logic [9:0] sent[$];
   logic [9:0] got[$];
   logic       got_sof[$];

   initial PIX_IN = '0;

   // Stamps taken at the same edge on both sides keep the latency exact
   always @(posedge CLOCK) begin
      cyc <= cyc + 1;
      if (PIX_IN.valid === 1'b1) t_in.push_back(cyc);
      if (PIX_OUT.valid === 1'b1) begin
         got.push_back(PIX_OUT.data);
         got_sof.push_back(PIX_OUT.sof);
         lat.push_back(cyc - t_in.pop_front());
      end
   end

   // Slow mode leaves gap idle cycles between pixels
   task automatic send_frame(input int n, input int base, input int gap);
      logic [9:0] p;
      for (int k = 0; k < n; k++) begin
         p = 10'((base + k * 37) & 32'h3ff);
         PIX_IN <= '{1'b1, k == 0, p};
         sent.push_back(p);
         @(posedge CLOCK);
         if (gap > 0) begin
            PIX_IN <= '{1'b0, 1'b0, ~p};
            repeat (gap) @(posedge CLOCK);
         end
      end
      PIX_IN <= '{1'b0, 1'b0, ~p};
   endtask
endmodule

// File: pixel_lut_flat_field.sv
// Purpose: Per-pixel shading correction followed by a programmable lookup table
// Assumes: Pixel stream comes from logic on CLOCK; APB master on CLOCK
// Notes:   Gain is unsigned 1.7 fixed point, 8'h80 is unity; zero wait for the stream
`timescale 1ns/1ps

module pixel_lut_flat_field #(
   parameter int NUM_PIX = 1024
) (
   // Clock and reset
   input  wire logic                   CLOCK,
   input  wire logic                   RST_B,
   // APB slave
   input  wire logic                   PSEL,
   input  wire logic                   PENABLE,
   input  wire logic                   PWRITE,
   input  wire logic [7:0]             PADDR,
   input  wire logic [31:0]            PWDATA,
   output logic      [31:0]            PRDATA,
   output logic                        PREADY,
   output logic                        PSLVERR,
   // Pixel stream
   input  pixel_lut_pkg::pixel_s       PIX_IN,
   output pixel_lut_pkg::pixel_s       PIX_OUT
);
   localparam int IDX_W = (NUM_PIX > 1) ? $clog2(NUM_PIX) : 1;

   function automatic logic [9:0] fmt_mask(input logic [9:0] d, input logic fmt10);
      return fmt10 ? d : {2'h0, d[7:0]};
   endfunction

   function automatic logic [9:0] ffc_fn(input logic [9:0] pix, input pixel_lut_pkg::coef_s c,
                                         input logic fmt10);
      logic [9:0]  p;
      logic [9:0]  diff;
      logic [17:0] prod;
      logic [10:0] scaled;
      logic [9:0]  maxv;
      p      = fmt_mask(pix, fmt10);
      maxv   = fmt10 ? pixel_lut_pkg::MAX_10 : pixel_lut_pkg::MAX_8;
      diff   = (p > {2'h0, c.offset}) ? p - {2'h0, c.offset} : 10'h000;
      prod   = {8'h00, diff} * {10'h000, c.gain};
      scaled = prod[17:pixel_lut_pkg::GAIN_FRAC];
      return (scaled > {1'b0, maxv}) ? maxv : scaled[9:0];
   endfunction

   // Register state
   logic [2:0]                ctrl_reg;
   logic [9:0]                tbl_addr_reg;
   logic [IDX_W-1:0]          coef_addr_reg;
   logic                      pready_reg;
   logic                      pslverr_reg;
   logic [31:0]               prdata_reg;
   logic [9:0]                table_mem  [1024];
   logic [9:0]                saved_tbl  [1024];
   pixel_lut_pkg::coef_s      coef_mem   [NUM_PIX];
   pixel_lut_pkg::coef_s      saved_coef [NUM_PIX];
   // Stream state
   logic [IDX_W-1:0]          pix_idx_reg;
   pixel_lut_pkg::pixel_s     s1_reg;
   pixel_lut_pkg::pixel_s     out_reg;

   wire lut_en = ctrl_reg[pixel_lut_pkg::CTRL_LUT_EN_BIT];
   wire fmt10  = ctrl_reg[pixel_lut_pkg::CTRL_FMT_BIT];
   wire ffc_en = ctrl_reg[pixel_lut_pkg::CTRL_FFC_EN_BIT];

   // Bus decode
   wire access    = PSEL && PENABLE && !pready_reg;
   wire commit    = PSEL && PENABLE && pready_reg && PWRITE && !pslverr_reg;
   wire hit_ctrl  = PADDR == pixel_lut_pkg::CTRL_OFS;
   wire hit_count = PADDR == pixel_lut_pkg::COUNT_OFS;
   wire hit_taddr = PADDR == pixel_lut_pkg::TBL_ADDR_OFS;
   wire hit_tdata = PADDR == pixel_lut_pkg::TBL_DATA_OFS;
   wire hit_caddr = PADDR == pixel_lut_pkg::COEF_ADDR_OFS;
   wire hit_cdata = PADDR == pixel_lut_pkg::COEF_DATA_OFS;
   wire hit_cmd   = PADDR == pixel_lut_pkg::CMD_OFS;
   wire mapped    = hit_ctrl || hit_count || hit_taddr || hit_tdata || hit_caddr || hit_cdata || hit_cmd;
   wire do_save    = commit && hit_cmd && PWDATA[pixel_lut_pkg::CMD_SAVE_BIT];
   wire do_restore = commit && hit_cmd && PWDATA[pixel_lut_pkg::CMD_RESTORE_BIT] && !do_save;

   wire [10:0] entry_count = fmt10 ? pixel_lut_pkg::ENTRIES_10 : pixel_lut_pkg::ENTRIES_8;
   wire [9:0]  tbl_wrap    = entry_count[9:0] - 10'h001;
   wire [9:0]  tbl_addr_nx = (tbl_addr_reg + 10'h001) & tbl_wrap;
   wire [IDX_W-1:0] coef_addr_nx = (coef_addr_reg == IDX_W'(NUM_PIX - 1)) ? '0 : coef_addr_reg + 1'b1;
   pixel_lut_pkg::coef_s coef_rd;
   assign coef_rd = coef_mem[coef_addr_reg];

   logic [31:0] rdata_next;
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (hit_ctrl) begin
         rdata_next = {29'h0, ctrl_reg};
      end else if (hit_count) begin
         rdata_next = {21'h0, entry_count};
      end else if (hit_taddr) begin
         rdata_next = {22'h0, tbl_addr_reg};
      end else if (hit_tdata) begin
         rdata_next = {22'h0, table_mem[tbl_addr_reg]};
      end else if (hit_caddr) begin
         rdata_next = 32'(coef_addr_reg);
      end else if (hit_cdata) begin
         rdata_next = {16'h0, coef_rd.gain, coef_rd.offset};
      end
   end

   // One wait state: read data is registered at the same edge that ready rises
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
      end else begin
         pready_reg  <= access;
         pslverr_reg <= access && !mapped;
         if (access && !PWRITE) begin
            prdata_reg <= rdata_next;
         end
      end
   end

   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         ctrl_reg      <= pixel_lut_pkg::CTRL_RESET;
         tbl_addr_reg  <= pixel_lut_pkg::ADDR_RESET;
         coef_addr_reg <= '0;
      end else if (commit) begin
         if (hit_ctrl) begin
            ctrl_reg <= PWDATA[2:0];
         end else if (hit_taddr) begin
            tbl_addr_reg <= PWDATA[9:0] & tbl_wrap;
         end else if (hit_tdata) begin
            tbl_addr_reg <= tbl_addr_nx;
         end else if (hit_caddr) begin
            coef_addr_reg <= PWDATA[IDX_W-1:0];
         end else if (hit_cdata) begin
            coef_addr_reg <= coef_addr_nx;
         end
      end
   end

   // Storage has no reset; a restore copies the whole saved set in one cycle
   always_ff @(posedge CLOCK) begin
      if (do_save) begin
         saved_tbl  <= table_mem;
         saved_coef <= coef_mem;
      end
      if (do_restore) begin
         table_mem <= saved_tbl;
         coef_mem  <= saved_coef;
      end else begin
         if (commit && hit_tdata) begin
            table_mem[tbl_addr_reg] <= fmt_mask(PWDATA[9:0], fmt10);
         end
         if (commit && hit_cdata) begin
            coef_mem[coef_addr_reg] <= '{gain: PWDATA[15:8], offset: PWDATA[7:0]};
         end
      end
   end

   // Stream: shading first, then table, one pixel per clock, never stalls
   wire [IDX_W-1:0] cur_idx = PIX_IN.sof ? '0 : pix_idx_reg;
   wire [9:0] ffc_val = ffc_fn(PIX_IN.data, coef_mem[cur_idx], fmt10);
   wire [9:0] s1_data = ffc_en ? ffc_val : fmt_mask(PIX_IN.data, fmt10);
   // Entries written in 10-bit form stay wide; mono 8 keeps the output to 8 bits
   wire [9:0] lut_val = fmt_mask(table_mem[fmt_mask(s1_reg.data, fmt10)], fmt10);
   wire [9:0] o_data  = lut_en ? lut_val : s1_reg.data;

   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         pix_idx_reg <= '0;
         s1_reg      <= '0;
         out_reg     <= '0;
      end else begin
         if (PIX_IN.valid) begin
            pix_idx_reg <= (cur_idx == IDX_W'(NUM_PIX - 1)) ? '0 : cur_idx + 1'b1;
         end
         s1_reg  <= '{valid: PIX_IN.valid, sof: PIX_IN.sof, data: s1_data};
         out_reg <= '{valid: s1_reg.valid, sof: s1_reg.sof, data: o_data};
      end
   end

   assign PRDATA  = prdata_reg;
   assign PREADY  = pready_reg;
   assign PSLVERR = pslverr_reg;
   assign PIX_OUT = out_reg;

   // Checks
   sequence cmd_save_s;
      commit && hit_cmd && PWDATA[pixel_lut_pkg::CMD_SAVE_BIT];
   endsequence

   sequence coef_write_s;
      commit && hit_cdata && !do_restore;
   endsequence

   chk_count_read: assert property (@(posedge CLOCK) disable iff (!RST_B)
      access && !PWRITE && hit_count |=> PREADY && PRDATA == (fmt10 ? 32'h0000_0400 : 32'h0000_0100))
      else $error("entry count read wrong");

   chk_stream_latency: assert property (@(posedge CLOCK) disable iff (!RST_B)
      PIX_IN.valid |-> ##2 PIX_OUT.valid)
      else $error("pixel not out after two cycles");

   chk_bypass_path: assert property (@(posedge CLOCK) disable iff (!RST_B)
      PIX_IN.valid && !lut_en && !ffc_en && fmt10 ##1 !lut_en |=> PIX_OUT.data == $past(PIX_IN.data, 2))
      else $error("bypass altered pixel");

   chk_table_subst: assert property (@(posedge CLOCK) disable iff (!RST_B)
      s1_reg.valid && lut_en && !do_restore |=> PIX_OUT.data == $past(lut_val))
      else $error("table entry not substituted");

   chk_format_width: assert property (@(posedge CLOCK) disable iff (!RST_B)
      s1_reg.valid && !fmt10 |=> PIX_OUT.data[9:8] == 2'h0)
      else $error("8-bit output exceeds 8 bits");

   chk_shading_apply: assert property (@(posedge CLOCK) disable iff (!RST_B)
      PIX_IN.valid && ffc_en |=> s1_reg.data == ffc_fn($past(PIX_IN.data), $past(coef_mem[cur_idx]), $past(fmt10)))
      else $error("shading correction not applied");

   chk_shading_off: assert property (@(posedge CLOCK) disable iff (!RST_B)
      PIX_IN.valid && !ffc_en |=> s1_reg.data == fmt_mask($past(PIX_IN.data), $past(fmt10)))
      else $error("shading applied while disabled");

   chk_save_copy: assert property (@(posedge CLOCK) disable iff (!RST_B)
      cmd_save_s |=> saved_tbl[0] == $past(table_mem[0]) && saved_coef[0] == $past(coef_mem[0]))
      else $error("save did not copy working set");

   chk_coef_store: assert property (@(posedge CLOCK) disable iff (!RST_B)
      coef_write_s ##1 !do_restore |-> coef_mem[$past(coef_addr_reg)] == {$past(PWDATA[15:8]), $past(PWDATA[7:0])})
      else $error("coefficient write lost");

   chk_apb_wait: assert property (@(posedge CLOCK) disable iff (!RST_B)
      access |-> !PREADY ##1 PREADY ##1 !PREADY)
      else $error("apb answer timing wrong");
endmodule

// File: pixel_lut_flat_field_tb.sv
// Purpose: Self-checking bench for the shading and table stage
// Assumes: APB with one wait state, two-cycle pixel latency
// Notes:   Small frame of 8 pixels keeps the coefficient set short
`timescale 1ns/1ps
module pixel_lut_flat_field_tb;
   localparam int NP = 8;
   localparam int AVG_FRAMES = 10;
   logic                  clock = 0;
   logic                  rst_b = 0;
   logic                  psel = 0;
   logic                  penable = 0;
   logic                  pwrite = 0;
   logic [7:0]            paddr = '0;
   logic [31:0]           pwdata = '0;
   logic [31:0]           prdata;
   logic                  pready;
   logic                  pslverr;
   pixel_lut_pkg::pixel_s pix_in;
   pixel_lut_pkg::pixel_s pix_out;
   int                    fails = 0;
   int                    tests_run = 0;
   logic [9:0]            tbl[1024];
   logic [7:0]            gn[NP];
   logic [7:0]            of[NP];
   logic [31:0]           rdv;
   logic                  err;

   always #2 clock = ~clock;

   pixel_lut_flat_field #(.NUM_PIX(NP)) DUT (.CLOCK(clock), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .PIX_IN(pix_in), .PIX_OUT(pix_out));
   pixel_feed feed (.CLOCK(clock), .PIX_OUT(pix_out), .PIX_IN(pix_in));

   task automatic end_of_test();
      if (fails == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // An idle cycle after each transfer avoids driving psel twice in one step
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge clock); n++; end while (pready !== 1'b1 && n < 50);
      if (n >= 50) fails++;
      rdv = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge clock);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, '0);
      chk(rdv, exp);
   endtask

   task automatic fill(input int n, input logic [9:0] mx, input int salt);
      apb(1'b1, pixel_lut_pkg::TBL_ADDR_OFS, '0);
      for (int i = 0; i < n; i++) begin
         tbl[i] = 10'(i * 7 + salt) & mx;
         apb(1'b1, pixel_lut_pkg::TBL_DATA_OFS, 32'(i * 7 + salt));
      end
   endtask

   function automatic logic [9:0] exp_pix(logic [9:0] p, int k, logic [2:0] c);
      logic [19:0] d;
      logic [9:0]  mx;
      mx = c[1] ? 10'h3ff : 10'h0ff;
      d = {10'h000, p & mx};
      if (c[2]) begin
         d = (d > of[k]) ? d - of[k] : 20'h00000;
         d = (d * gn[k]) >> 7;
         if (d > mx) d = mx;
      end
      if (c[0]) d = {10'h000, tbl[d[9:0]] & mx};
      return d[9:0];
   endfunction

   task automatic run(input logic [2:0] c, input int base, input int gap);
      feed.sent.delete(); feed.got.delete(); feed.lat.delete(); feed.got_sof.delete();
      apb(1'b1, pixel_lut_pkg::CTRL_OFS, {29'h0, c});
      feed.send_frame(NP, base, gap);
      repeat (4) @(posedge clock);
      chk(feed.got.size(), NP);
      foreach (feed.sent[k]) begin
         chk(feed.got[k], exp_pix(feed.sent[k], k, c));
         chk(feed.lat[k], 2);
         chk(feed.got_sof[k], k == 0);
      end
   endtask

   task automatic set_a();
      for (int k = 0; k < NP; k++) begin
         gn[k] = 8'(k * 40 + 96);
         of[k] = 8'(k * 23);
      end
   endtask

   task automatic load_coefs();
      apb(1'b1, pixel_lut_pkg::COEF_ADDR_OFS, 32'h0);
      for (int k = 0; k < NP; k++) begin
         apb(1'b1, pixel_lut_pkg::COEF_DATA_OFS, {16'h0, gn[k], of[k]});
      end
   endtask

   // Host side: average dark and light gray references, then turn them into coefficients
   task automatic derive(input int frames);
      int dk;
      int wt;
      for (int k = 0; k < NP; k++) begin
         dk = 0;
         wt = 0;
         for (int f = 0; f < frames; f++) begin
            dk += k * 2 + f % 3;
            wt += 150 + k * 9 + f % 4;
         end
         dk = dk / frames;
         wt = wt / frames;
         chk(dk < 20 && wt > 128, 1'b1);
         of[k] = 8'(dk);
         gn[k] = 8'(250 * 128 / (wt - dk));
      end
   endtask

   initial begin
      repeat (20000) @(posedge clock);
      fails++;
      end_of_test();
   end

   initial begin
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      rd_chk(pixel_lut_pkg::CTRL_OFS, 32'h0);
      rd_chk(pixel_lut_pkg::COUNT_OFS, 32'h100);
      rd_chk(8'h1c, 32'h0);
      chk(err, 1'b1);
      run(3'b010, 100, 0);
      apb(1'b1, pixel_lut_pkg::CTRL_OFS, 32'h1);
      fill(256, 10'h0ff, 3);
      apb(1'b1, pixel_lut_pkg::TBL_ADDR_OFS, 32'h5);
      rd_chk(pixel_lut_pkg::TBL_DATA_OFS, {22'h0, tbl[5]});
      run(3'b001, 0, 0);
      apb(1'b1, pixel_lut_pkg::CTRL_OFS, 32'h2);
      rd_chk(pixel_lut_pkg::COUNT_OFS, 32'h400);
      fill(1024, 10'h3ff, 5);
      run(3'b011, 500, 2);
      set_a();
      load_coefs();
      rd_chk(pixel_lut_pkg::COEF_DATA_OFS, {16'h0, gn[0], of[0]});
      run(3'b110, 300, 0);
      run(3'b111, 700, 1);
      apb(1'b1, pixel_lut_pkg::CMD_OFS, 32'h1);
      apb(1'b1, pixel_lut_pkg::TBL_ADDR_OFS, 32'h0);
      apb(1'b1, pixel_lut_pkg::TBL_DATA_OFS, 32'h2aa);
      apb(1'b1, pixel_lut_pkg::TBL_ADDR_OFS, 32'h0);
      rd_chk(pixel_lut_pkg::TBL_DATA_OFS, 32'h2aa);
      derive(AVG_FRAMES);
      load_coefs();
      run(3'b110, 900, 0);
      apb(1'b1, pixel_lut_pkg::CMD_OFS, 32'h2);
      rd_chk(pixel_lut_pkg::TBL_DATA_OFS, {22'h0, tbl[0]});
      set_a();
      run(3'b101, 20, 0);
      run(3'b010, 40, 0);
      end_of_test();
   end
endmodule

// File: pixel_lut_pkg.sv
// Purpose: Shared constants and carrier types for the pixel table and shading stage
// Assumes: APB register access with 32-bit data, one pixel per clock
// Notes:   Offsets are byte addresses of aligned 32-bit words
package pixel_lut_pkg;
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 32;
   localparam int          PIX_W           = 10;
   localparam int          TBL_AW          = 10;
   localparam int          COEF_W          = 8;
   localparam int          GAIN_FRAC       = 7;
   // Register offsets
   localparam logic [7:0]  CTRL_OFS        = 8'h00;
   localparam logic [7:0]  COUNT_OFS       = 8'h04;
   localparam logic [7:0]  TBL_ADDR_OFS    = 8'h08;
   localparam logic [7:0]  TBL_DATA_OFS    = 8'h0c;
   localparam logic [7:0]  COEF_ADDR_OFS   = 8'h10;
   localparam logic [7:0]  COEF_DATA_OFS   = 8'h14;
   localparam logic [7:0]  CMD_OFS         = 8'h18;
   // Field positions
   localparam int          CTRL_LUT_EN_BIT = 0;
   localparam int          CTRL_FMT_BIT    = 1;
   localparam int          CTRL_FFC_EN_BIT = 2;
   localparam int          CMD_SAVE_BIT    = 0;
   localparam int          CMD_RESTORE_BIT = 1;
   localparam int          COEF_GAIN_LSB   = 8;
   localparam int          COEF_OFFS_LSB   = 0;
   // Reset values
   localparam logic [2:0]  CTRL_RESET      = 3'h0;
   localparam logic [9:0]  ADDR_RESET      = 10'h000;
   // Entry counts and pixel maxima of the two table formats
   localparam logic [10:0] ENTRIES_8       = 11'h100;
   localparam logic [10:0] ENTRIES_10      = 11'h400;
   localparam logic [9:0]  MAX_8           = 10'h0ff;
   localparam logic [9:0]  MAX_10          = 10'h3ff;

   typedef enum logic {FMT_MONO8, FMT_MONO10} table_format_e;

   typedef struct packed {
      logic             valid;
      logic             sof;
      logic [PIX_W-1:0] data;
   } pixel_s;

   typedef struct packed {
      logic [COEF_W-1:0] gain;
      logic [COEF_W-1:0] offset;
   } coef_s;
endpackage
